// ==== scd_pkg.sv ====
`default_nettype none
package scd_pkg;
	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int          FRAME_BITS    = 29;
	localparam int          RW_BIT        = 28;
	localparam int          CH_MSB        = 27;
	localparam int          CH_LSB        = 24;
	localparam int          GRP_MSB       = 23;
	localparam int          GRP_LSB       = 22;
	localparam int          DATA_W        = 22;
	localparam logic [21:0] NOP_DATA      = 22'h3fffff;
	localparam logic [21:0] DATA_RST      = 22'h000000;
	localparam logic [4:0]  BITCNT_RST    = 5'h00;

	// ----------------------------------------------------------------
	// Register groups
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_CTRL   = 2'h0;
	localparam logic [1:0] GRP_GAIN   = 2'h1;
	localparam logic [1:0] GRP_OFFSET = 2'h2;
	localparam logic [1:0] GRP_CODE   = 2'h3;

	// ----------------------------------------------------------------
	// Register map (AXI4-Lite byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_SYSCTRL = 8'h04;
	localparam logic [7:0] ADDR_CHCTRL0 = 8'h10;
	localparam logic [7:0] ADDR_GAIN0   = 8'h20;
	localparam logic [7:0] ADDR_OFFS0   = 8'h30;
	localparam logic [7:0] ADDR_CODE0   = 8'h40;
	localparam logic [7:0] ADDR_RDREQ   = 8'h50;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		SCD_RD_SYSCTRL  = 2'h0,
		SCD_RD_COMP     = 2'h1,
		SCD_RD_CHANNEL  = 2'h2,
		SCD_RD_ALARM    = 2'h3
	} scd_rdsrc_e;
endpackage : scd_pkg
`default_nettype wire

// ==== scd_decoder.sv ====
// What this block does
// - A frame is 29 bits, opened by sync falling, clocked on falling edges.
// - Register update happens only on sync rising; next frame needs sync low.
// - Header bits 28..22 mean the same for reads and writes when exactly one channel bit is set.
// - Read/write bit set starts a readback chosen by address and group.
// - Bits 27..24 select channels 3..0, one bit each.
// - A write applies the same data to every selected channel at once.
// - Group 00 control, 01 gain, 10 offset, 11 input code.
// - No channels and group 00 writes the system control register.
// - No channels, group 11, data all ones is a no-op.
// - No channels with group 01, 10 or 11 non-ones is reserved.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module scd_decoder
#(
	parameter int CHANNELS = 4
)
(
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	input  wire logic                     sync_n,
	input  wire logic                     sclk,
	input  wire logic                     sdi,
	input  wire logic [CHANNELS-1:0]      comp_status,
	input  wire logic [CHANNELS-1:0]      alarm_status,
	input  wire logic [7:0]               s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [7:0]               s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	output logic [scd_pkg::DATA_W-1:0]    readback_data,
	output logic                          readback_strobe
);
	import scd_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [2:0] sync_s1_reg, sync_s2_reg, sync_s3_reg;
	logic [2:0] sync_s1_next, sync_s2_next, sync_s3_next;

	always_comb
	begin
		sync_s1_next = {sync_n, sclk, sdi};
		sync_s2_next = sync_s1_reg;
		sync_s3_next = sync_s2_reg;
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_s1_reg <= 3'h7;
			sync_s2_reg <= 3'h7;
			sync_s3_reg <= 3'h7;
		end
		else
		begin
			sync_s1_reg <= sync_s1_next;
			sync_s2_reg <= sync_s2_next;
			sync_s3_reg <= sync_s3_next;
		end
	end

	logic sync_fall, sync_rise, sclk_fall, in_frame;
	assign sync_fall = sync_s3_reg[2] && !sync_s2_reg[2];
	assign sync_rise = !sync_s3_reg[2] && sync_s2_reg[2];
	assign sclk_fall = sync_s3_reg[1] && !sync_s2_reg[1];
	assign in_frame  = !sync_s2_reg[2];

	// ----------------------------------------------------------------
	// Frame shifter
	// ----------------------------------------------------------------
	logic [FRAME_BITS-1:0] shift_reg, shift_next;
	logic [4:0]            bitcnt_reg, bitcnt_next;

	always_comb
	begin
		shift_next  = shift_reg;
		bitcnt_next = bitcnt_reg;
		if (sync_fall)
			bitcnt_next = BITCNT_RST;
		else if (in_frame && sclk_fall)
		begin
			shift_next = {shift_reg[FRAME_BITS-2:0], sync_s2_reg[0]};
			if (bitcnt_reg != 5'(FRAME_BITS))
				bitcnt_next = bitcnt_reg + 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			shift_reg  <= '0;
			bitcnt_reg <= BITCNT_RST;
		end
		else
		begin
			shift_reg  <= shift_next;
			bitcnt_reg <= bitcnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	// Extra clocks beyond 29 keep only the last 29 bits, as a shifter would
	logic                 is_read;
	logic [3:0]           ch_sel;
	logic [1:0]           grp;
	logic [DATA_W-1:0]    cmd_data;
	logic                 frame_ok;
	assign is_read  = shift_reg[RW_BIT];
	assign ch_sel   = shift_reg[CH_MSB:CH_LSB];
	assign grp      = shift_reg[GRP_MSB:GRP_LSB];
	assign cmd_data = shift_reg[DATA_W-1:0];
	assign frame_ok = sync_rise && bitcnt_reg == 5'(FRAME_BITS);

	// ----------------------------------------------------------------
	// Target registers
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] sysctrl_reg, sysctrl_next;
	logic [DATA_W-1:0] chctrl_reg [CHANNELS], chctrl_next [CHANNELS];
	logic [DATA_W-1:0] gain_reg   [CHANNELS], gain_next   [CHANNELS];
	logic [DATA_W-1:0] offs_reg   [CHANNELS], offs_next   [CHANNELS];
	logic [DATA_W-1:0] code_reg   [CHANNELS], code_next   [CHANNELS];
	logic [DATA_W-1:0] rb_reg, rb_next;
	logic              rbs_reg, rbs_next;
	logic              rsv_reg, rsv_next;
	logic              nop_reg, nop_next;
	logic [1:0]        rdch;
	logic              wr_clear;

	always_comb
	begin
		rdch = 2'h0;
		for (int i = 0; i < CHANNELS; i++)
			if (ch_sel[i])
				rdch = 2'(i);
	end

	always_comb
	begin
		sysctrl_next = sysctrl_reg;
		chctrl_next  = chctrl_reg;
		gain_next    = gain_reg;
		offs_next    = offs_reg;
		code_next    = code_reg;
		rb_next      = rb_reg;
		rbs_next     = 1'b0;
		// A set further down wins over a clear in the same cycle
		rsv_next     = rsv_reg && !(wr_clear && s_axi_wdata[0]);
		nop_next     = nop_reg && !(wr_clear && s_axi_wdata[1]);
		if (frame_ok)
		begin
			if (is_read)
			begin
				rbs_next = 1'b1;
				if (ch_sel == 4'h0)
				begin
					case (grp)
						GRP_CTRL:   rb_next = sysctrl_reg;
						GRP_GAIN:   rb_next = DATA_W'(comp_status);
						GRP_CODE:   rb_next = DATA_W'(alarm_status);
						default:
						begin
							rbs_next = 1'b0;
							rsv_next = 1'b1;
						end
					endcase
					if (cmd_data != DATA_RST)
					begin
						// Readback holds its last value when no load happens
						rb_next  = rb_reg;
						rbs_next = 1'b0;
						rsv_next = 1'b1;
					end
				end
				else if ($countones(ch_sel) != 1)
				begin
					rbs_next = 1'b0;
					rsv_next = 1'b1;
				end
				else
				begin
					case (grp)
						GRP_CTRL:   rb_next = chctrl_reg[rdch];
						GRP_GAIN:   rb_next = gain_reg[rdch];
						GRP_OFFSET: rb_next = offs_reg[rdch];
						default:    rb_next = code_reg[rdch];
					endcase
				end
			end
			else if (ch_sel == 4'h0)
			begin
				if (grp == GRP_CTRL)
					sysctrl_next = cmd_data;
				else if (grp == GRP_CODE && cmd_data == NOP_DATA)
					nop_next = 1'b1;
				else
					rsv_next = 1'b1;
			end
			else
			begin
				for (int i = 0; i < CHANNELS; i++)
					if (ch_sel[i])
						case (grp)
							GRP_CTRL:   chctrl_next[i] = cmd_data;
							GRP_GAIN:   gain_next[i]   = cmd_data;
							GRP_OFFSET: offs_next[i]   = cmd_data;
							default:    code_next[i]   = cmd_data;
						endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sysctrl_reg <= DATA_RST;
			chctrl_reg  <= '{default: DATA_RST};
			gain_reg    <= '{default: DATA_RST};
			offs_reg    <= '{default: DATA_RST};
			code_reg    <= '{default: DATA_RST};
			rb_reg      <= DATA_RST;
			rbs_reg     <= 1'b0;
			rsv_reg     <= 1'b0;
			nop_reg     <= 1'b0;
		end
		else
		begin
			sysctrl_reg <= sysctrl_next;
			chctrl_reg  <= chctrl_next;
			gain_reg    <= gain_next;
			offs_reg    <= offs_next;
			code_reg    <= code_next;
			rb_reg      <= rb_next;
			rbs_reg     <= rbs_next;
			rsv_reg     <= rsv_next;
			nop_reg     <= nop_next;
		end
	end

	assign readback_data   = rb_reg;
	assign readback_strobe = rbs_reg;

	// ----------------------------------------------------------------
	// AXI4-Lite slave (read-only view; status flags write-one-to-clear)
	// ----------------------------------------------------------------
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0]  ra;
	logic [1:0]  ri;

	assign wr_clear = s_axi_awvalid && s_axi_wvalid && !bvalid_reg
		&& s_axi_awaddr == ADDR_STATUS && s_axi_wstrb[0];

	assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
	assign s_axi_wready  = s_axi_awready;
	assign s_axi_arready = s_axi_arvalid && !rvalid_reg;
	assign ra = s_axi_araddr;
	assign ri = ra[3:2];

	always_comb
	begin
		bvalid_next = bvalid_reg && !s_axi_bready;
		bresp_next  = bresp_reg;
		rvalid_next = rvalid_reg && !s_axi_rready;
		rresp_next  = rresp_reg;
		rdata_next  = rdata_reg;
		if (s_axi_awready)
		begin
			bvalid_next = 1'b1;
			bresp_next  = s_axi_awaddr == ADDR_STATUS ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_axi_arready)
		begin
			rvalid_next = 1'b1;
			rresp_next  = RESP_OKAY;
			rdata_next  = 32'h0;
			case (ra & 8'hf0)
				ADDR_STATUS:
					if (ra == ADDR_STATUS)
						rdata_next = {30'h0, nop_reg, rsv_reg};
					else if (ra == ADDR_SYSCTRL)
						rdata_next = 32'(sysctrl_reg);
					else
						rresp_next = RESP_SLVERR;
				ADDR_CHCTRL0: rdata_next = 32'(chctrl_reg[ri]);
				ADDR_GAIN0:   rdata_next = 32'(gain_reg[ri]);
				ADDR_OFFS0:   rdata_next = 32'(offs_reg[ri]);
				ADDR_CODE0:   rdata_next = 32'(code_reg[ri]);
				ADDR_RDREQ:   rdata_next = 32'(rb_reg);
				default:      rresp_next = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= 32'h0;
		end
		else
		begin
			bvalid_reg <= bvalid_next;
			bresp_reg  <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg  <= rresp_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;
endmodule : scd_decoder
`default_nettype wire

// ==== scd_decoder_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module scd_decoder_props
(
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic        sync_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [21:0] readback_data,
	input wire logic        readback_strobe
);
	import scd_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	chk_strobe_pulse: assert property (
		readback_strobe |=> !readback_strobe) else $error("long strobe");
	// Sync is resynchronised, so it must have stood high for two cycles
	chk_strobe_sync: assert property (
		readback_strobe |-> sync_n && $past(sync_n, 2)) else $error("early load");
	chk_rb_hold: assert property (
		$changed(readback_data) |-> readback_strobe) else $error("rb moved");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |=> s_axi_bvalid) else $error("no b");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
	chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 8'hfc |=> s_axi_rresp == RESP_SLVERR) else $error("no err");
	cover property (readback_strobe);
	cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	cover property ($rose(sync_n));
endmodule : scd_decoder_props
`default_nettype wire

// ==== scd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module scd_host_model
(
	output logic sync_n,
	output logic sclk,
	output logic sdi
);
	initial
	begin
		sync_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end
	// Sends n bits, MSB first; n above 29 repeats low bits first
	task automatic send(input logic [28:0] w, input int n);
		sync_n = 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			sdi = w[i % 29];
			#200 sclk = 1'b0;
			#200 sclk = 1'b1;
		end
		// Released line shows the inverse, not a stale valid bit
		sdi = ~sdi;
		#200 sync_n = 1'b1;
		#1000;
	endtask : send
endmodule : scd_host_model
`default_nettype wire

// ==== tb_scd_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_scd_decoder;
	import scd_pkg::*;
	logic        core_clk = 1'b0;
	logic        rstn = 1'b0;
	wire logic   sync_n, sclk, sdi;
	logic [3:0]  comp_status = '0, alarm_status = '0, m, s_axi_wstrb = 4'hf;
	logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic        s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, readback_strobe;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [21:0] readback_data, d, rbx, sys = '0;
	logic [21:0] rg [4][4] = '{default: '0};
	logic [33:0] e, axq [$];
	logic [21:0] rbq [$];
	int          errors = 0;
	int          check_count = 0;
	always #25 core_clk = ~core_clk;
	scd_host_model u_scd_host_model (.sync_n, .sclk, .sdi);
	scd_decoder u_scd_decoder (.core_clk, .rstn, .sync_n, .sclk, .sdi,
		.comp_status, .alarm_status, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .readback_data,
		.readback_strobe);
	always @(posedge core_clk)
	begin
		if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready)
		begin
			e = axq.pop_front();
			// Error replies carry no defined data, so only the code counts
			if (s_axi_bvalid || e[33])
				`CHK(s_axi_bvalid ? s_axi_bresp : s_axi_rresp, e[33:32])
			else
				`CHK({s_axi_rresp, s_axi_rdata}, e)
		end
		if (readback_strobe)
		begin
			rbx = rbq.pop_front();
			`CHK(readback_data, rbx)
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axq.push_back({RESP_OKAY, 32'h0});
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (!s_axi_bvalid) @(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [33:0] v);
		axq.push_back(v);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdv(input logic [7:0] a, input logic [21:0] v);
		rd(a, {RESP_OKAY, 10'h0, v});
	endtask : rdv
	task automatic fr(logic rw, logic [3:0] c, logic [1:0] g, logic [21:0] v);
		u_scd_host_model.send({rw, c, g, v}, 29);
	endtask : fr
	task automatic chk_all;
		rdv(ADDR_SYSCTRL, sys);
		for (int g = 0; g < 4; g++)
			for (int c = 0; c < 4; c++)
				rdv(ADDR_CHCTRL0 + 8'(16 * g + 4 * c), rg[g][c]);
	endtask : chk_all
	task automatic report_and_stop;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#2000000;
		errors++;
		report_and_stop();
	end
	initial
	begin
		void'($urandom(40));
		repeat (10) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk_all();
		rd(8'hfc, {RESP_SLVERR, 32'h0});
		sys = 22'($urandom);
		fr(1'b0, 4'h0, GRP_CTRL, sys);
		for (int k = 0; k < 8; k++)
		begin
			m = 4'($urandom_range(15, 1));
			d = 22'($urandom);
			fr(1'b0, m, 2'(k), d);
			for (int c = 0; c < 4; c++)
				if (m[c])
					rg[k % 4][c] = d;
		end
		chk_all();
		fr(1'b0, 4'h0, GRP_CODE, NOP_DATA);
		rdv(ADDR_STATUS, 22'h2);
		wr(ADDR_STATUS, 32'h3);
		fr(1'b0, 4'h0, GRP_GAIN, 22'($urandom));
		fr(1'b0, 4'h0, GRP_OFFSET, 22'($urandom));
		fr(1'b0, 4'h0, GRP_CODE, NOP_DATA ^ 22'h1);
		rdv(ADDR_STATUS, 22'h1);
		wr(ADDR_STATUS, 32'h3);
		rdv(ADDR_STATUS, 22'h0);
		// Too short is dropped; too long keeps the last 29 bits
		u_scd_host_model.send({7'h0, ~sys}, 20);
		rdv(ADDR_SYSCTRL, sys);
		sys = 22'($urandom);
		u_scd_host_model.send({7'h0, sys}, 35);
		chk_all();
		@(posedge core_clk);
		comp_status <= 4'($urandom);
		alarm_status <= 4'($urandom);
		rbq.push_back(sys);
		fr(1'b1, 4'h0, GRP_CTRL, 22'h0);
		rbq.push_back({18'h0, comp_status});
		fr(1'b1, 4'h0, GRP_GAIN, 22'h0);
		rbq.push_back({18'h0, alarm_status});
		fr(1'b1, 4'h0, GRP_CODE, 22'h0);
		fr(1'b0, 4'h0, GRP_CODE, NOP_DATA);
		for (int c = 0; c < 4; c++)
		begin
			rbq.push_back(rg[c][c]);
			fr(1'b1, 4'h1 << c, 2'(c), 22'h0);
		end
		fr(1'b1, 4'h0, GRP_OFFSET, 22'h0);
		fr(1'b1, 4'h3, GRP_CTRL, 22'h0);
		rdv(ADDR_STATUS, 22'h3);
		`CHK(rbq.size(), 0)
		report_and_stop();
	end
endmodule : tb_scd_decoder
bind scd_decoder scd_decoder_props u_scd_decoder_props (.core_clk, .rstn,
	.sync_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .readback_data, .readback_strobe);
`default_nettype wire
